// ---- core/scm_sspa_menu.sv ----
// Front-panel menu for amplifier compensation type, interface mode and power-up mode.
//
// Function
// - Function buttons step menu forward or back.
// - Changed uncommitted value shows flashing.
// - Enter commits pending value, stops flashing.
// - Leaving a parameter discards pending value.
// - Fault control disabled forces compensation Off.
// - Illegal non-Off compensation commit refused with error.
// - List holds Off, standards, three customs.
// - Uploaded individual table adds one entry.
// - Amplifier-supplied characteristic sets type automatically.
// - Amplifier info read once; reset refreshes.
// - Standard name is model plus suffix.
// - Data buttons scroll compensation entries.
// - Up data toggles Extended and Basic.
// - Extended mode enables richer amplifier feedback.
// - No-transmit power-up keeps amplifier off.
// - Restore power-up returns previous activation.
// - Up data toggles power-up mode values.
// - Early converters show power-up mode N/A.
`timescale 1ns/1ns
`default_nettype none
module scm_sspa_menu
   import scm_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [BTN_W-1:0] btn_raw,
   input wire logic amp_present,
   input wire logic amp_has_char,
   input wire logic [MODEL_W-1:0] amp_model,
   input wire logic [NV_W-1:0] nv_rdata,
   output logic nv_wr,
   output logic [NV_W-1:0] nv_wdata,
   output logic [2:0] disp_page,
   output logic [VAL_W-1:0] disp_value,
   output logic disp_flash,
   output logic disp_err,
   output logic disp_na,
   output logic disp_std,
   output logic [MODEL_W-1:0] disp_model,
   output logic amp_activate,
   output logic amp_ext_feedback
);
   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   scm_sync_if #(.W(BTN_W)) key_if ();
   scm_sync_if #(.W(AMP_W)) amp_if ();

   scm_sync #(.W(BTN_W)) u_key_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .raw(btn_raw),
      .port(key_if)
   );

   scm_sync #(.W(AMP_W)) u_amp_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .raw({amp_has_char, amp_present, amp_model}),
      .port(amp_if)
   );

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   scm_page_t page_ff;
   scm_page_t nxt_page;
   logic [VAL_W-1:0] comp_ff;
   logic [VAL_W-1:0] nxt_comp;
   logic mode_ff;
   logic nxt_mode;
   logic pwr_ff;
   logic nxt_pwr;
   logic act_ff;
   logic nxt_act;
   logic edit_ff;
   logic nxt_edit;
   logic [VAL_W-1:0] pend_ff;
   logic err_ff;
   logic boot_ff;
   logic info_ff;
   logic has_char_ff;
   logic [MODEL_W-1:0] model_ff;
   logic fault_en_ff;
   logic supplies_ff;
   logic pwr_na_ff;
   logic [LOAD_W-1:0] loaded_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic nv_wr_ff;
   logic [NV_W-1:0] nv_wdata_ff;
   logic [2:0] disp_page_ff;
   logic [VAL_W-1:0] disp_value_ff;
   logic disp_flash_ff;
   logic disp_na_ff;
   logic disp_std_ff;
   logic ext_fb_ff;

   // ----------------------------------------------------------------
   // Compensation list stepping
   // ----------------------------------------------------------------
   function automatic logic [VAL_W-1:0] step_avail(
      input logic [VAL_W-1:0] cur,
      input logic [COMP_N-1:0] av,
      input logic up
   );
      logic [VAL_W-1:0] cand;
      logic [VAL_W-1:0] res;
      logic hit;
      res = cur;
      hit = 1'b0;
      for (int i = 1; i < COMP_N; i++) begin
         cand = up ? cur + VAL_W'(i) : cur - VAL_W'(i);
         if (!hit && av[cand]) begin
            res = cand;
            hit = 1'b1;
         end
      end
      return res;
   endfunction : step_avail

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire fup = key_if.rise[BTN_FUP];
   wire fdn = key_if.rise[BTN_FDN];
   wire dup = key_if.rise[BTN_DUP];
   wire ddn = key_if.rise[BTN_DDN];
   wire ent = key_if.rise[BTN_ENT];
   wire any_key = |key_if.rise;
   wire fn_move = fup | fdn;
   wire on_comp = (page_ff == PG_COMP);
   wire on_mode = (page_ff == PG_MODE);
   wire on_pwr = (page_ff == PG_PWR);

   wire apb_acc = psel & penable & ~pready_ff;
   wire apb_done = psel & penable & pready_ff;
   wire sel_ctrl = (paddr == ADDR_CTRL);
   wire sel_load = (paddr == ADDR_LOAD);
   wire sel_stat = (paddr == ADDR_STAT);
   wire mapped = sel_ctrl | sel_load | sel_stat;
   wire wr_ctrl = apb_done & pwrite & sel_ctrl;
   wire wr_load = apb_done & pwrite & sel_load;

   // Converter-held lists offer every standard; an amplifier that carries its own
   // characteristic offers only its one standard, and only if it reported one.
   wire [2:0] std_av = supplies_ff ? {2'b00, has_char_ff} : 3'b111;
   wire [COMP_N-1:0] avail = {loaded_ff[LOAD_TABLE], loaded_ff[2:0], std_av, 1'b1};

   wire [VAL_W-1:0] cur_val = on_comp ? comp_ff : {2'b00, on_mode ? mode_ff : pwr_ff};
   wire [VAL_W-1:0] shown = edit_ff ? pend_ff : cur_val;
   wire pwr_locked = on_pwr & pwr_na_ff;
   wire data_ev = on_comp ? (dup | ddn) : (dup & ~pwr_locked);
   wire [VAL_W-1:0] comp_step = step_avail(shown, avail, dup);
   wire [VAL_W-1:0] tog_val = {2'b00, ~shown[0]};
   wire [VAL_W-1:0] new_val = on_comp ? comp_step : tog_val;
   wire commit = ent & edit_ff & ~fn_move;
   // Basic mode cannot be combined with compensation; the operator is expected
   // to choose Off, and a non-Off commit in that state is refused here.
   wire illegal = on_comp & (pend_ff != COMP_OFF) & (~fault_en_ff | (mode_ff == MODE_BASIC));
   wire commit_ok = commit & ~illegal;
   wire capture = ~boot_ff & ~info_ff & amp_if.lvl[AMP_PRESENT];
   wire [VAL_W-1:0] cap_comp = amp_if.lvl[AMP_HAS_CHAR] ? COMP_STD_A : COMP_OFF;
   wire flash = edit_ff & (pend_ff != cur_val);

   // ----------------------------------------------------------------
   // Next-state selection
   // ----------------------------------------------------------------
   always_comb begin
      case (page_ff)
         PG_COMP: nxt_page = fup ? PG_MODE : (fdn ? PG_PWR : PG_COMP);
         PG_MODE: nxt_page = fup ? PG_PWR : (fdn ? PG_COMP : PG_MODE);
         PG_PWR: nxt_page = fup ? PG_COMP : (fdn ? PG_MODE : PG_PWR);
         default: nxt_page = PG_COMP;
      endcase
   end

   always_comb begin
      if (boot_ff) begin
         nxt_comp = nv_rdata[VAL_W-1:0];
      end else if (!fault_en_ff) begin
         nxt_comp = COMP_OFF;
      end else if (capture && supplies_ff) begin
         nxt_comp = cap_comp;
      end else if (commit_ok && on_comp) begin
         nxt_comp = pend_ff;
      end else begin
         nxt_comp = comp_ff;
      end
   end

   assign nxt_mode = boot_ff ? nv_rdata[NV_MODE] : ((commit_ok & on_mode) ? pend_ff[0] : mode_ff);
   assign nxt_pwr = boot_ff ? nv_rdata[NV_PWR] : ((commit_ok & on_pwr) ? pend_ff[0] : pwr_ff);
   // Power-up activation follows the stored power-up mode in the saved word.
   assign nxt_act = boot_ff ? ((nv_rdata[NV_PWR] == PWR_NO_TRANSMIT_AT_POWER_UP) ? 1'b0 : nv_rdata[NV_ACT])
      : (wr_ctrl ? pwdata[CTRL_ACT] : act_ff);
   // Leaving the parameter drops the edit without touching the stored value.
   assign nxt_edit = fn_move ? 1'b0 : (commit_ok ? 1'b0 : (data_ev ? 1'b1 : edit_ff));

   wire [NV_W-1:0] cur_word = {act_ff, pwr_ff, mode_ff, comp_ff};
   wire [NV_W-1:0] nxt_word = {nxt_act, nxt_pwr, nxt_mode, nxt_comp};

   wire [31:0] stat_word = {20'h0_0000, page_ff, info_ff, err_ff, edit_ff, act_ff, pwr_ff, mode_ff, comp_ff};
   wire [31:0] ctrl_word = {28'h000_0000, pwr_na_ff, supplies_ff, act_ff, fault_en_ff};
   wire [31:0] load_word = {28'h000_0000, loaded_ff};
   wire [31:0] rd_word = sel_ctrl ? ctrl_word : (sel_load ? load_word : (sel_stat ? stat_word : RD_ZERO));

   // ----------------------------------------------------------------
   // Menu registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         page_ff <= PG_COMP;
         comp_ff <= COMP_OFF;
         mode_ff <= MODE_EXT;
         pwr_ff <= PWR_NO_TRANSMIT_AT_POWER_UP;
         act_ff <= 1'b0;
         edit_ff <= 1'b0;
         pend_ff <= COMP_OFF;
         boot_ff <= 1'b1;
         ext_fb_ff <= 1'b0;
      end else begin
         page_ff <= nxt_page;
         comp_ff <= nxt_comp;
         mode_ff <= nxt_mode;
         pwr_ff <= nxt_pwr;
         act_ff <= nxt_act;
         edit_ff <= nxt_edit;
         pend_ff <= data_ev ? new_val : pend_ff;
         boot_ff <= 1'b0;
         ext_fb_ff <= (nxt_mode == MODE_EXT);
      end
   end

   // A refusal sets the error; any later key press clears it, a new refusal wins.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         err_ff <= 1'b0;
      end else begin
         err_ff <= (commit & illegal) | (err_ff & ~any_key);
      end
   end

   // Amplifier details are taken once per reset; later plug changes are ignored
   // on purpose, so a stale model shows until the controller is reset.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         info_ff <= 1'b0;
         has_char_ff <= 1'b0;
         model_ff <= '0;
      end else if (capture) begin
         info_ff <= 1'b1;
         has_char_ff <= amp_if.lvl[AMP_HAS_CHAR];
         model_ff <= amp_if.lvl[MODEL_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         nv_wr_ff <= 1'b0;
         nv_wdata_ff <= '0;
      end else begin
         nv_wr_ff <= ~boot_ff & (nxt_word != cur_word);
         nv_wdata_ff <= nxt_word;
      end
   end

   // ----------------------------------------------------------------
   // Display
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         disp_page_ff <= PG_COMP;
         disp_value_ff <= COMP_OFF;
         disp_flash_ff <= 1'b0;
         disp_na_ff <= 1'b0;
         disp_std_ff <= 1'b0;
      end else begin
         disp_page_ff <= page_ff;
         disp_value_ff <= shown;
         disp_flash_ff <= flash;
         disp_na_ff <= pwr_locked;
         disp_std_ff <= on_comp & supplies_ff & (shown == COMP_STD_A);
      end
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fault_en_ff <= CTRL_RST[CTRL_FAULT_EN];
         supplies_ff <= CTRL_RST[CTRL_SUPPLIES];
         pwr_na_ff <= CTRL_RST[CTRL_PWR_NA];
         loaded_ff <= '0;
      end else begin
         if (wr_ctrl) begin
            fault_en_ff <= pwdata[CTRL_FAULT_EN];
            supplies_ff <= pwdata[CTRL_SUPPLIES];
            pwr_na_ff <= pwdata[CTRL_PWR_NA];
         end
         if (wr_load) begin
            loaded_ff <= pwdata[LOAD_W-1:0];
         end
      end
   end

   // One wait state: the answer is prepared in the first access cycle.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= RD_ZERO;
      end else begin
         pready_ff <= apb_acc;
         pslverr_ff <= apb_acc & ~mapped;
         prdata_ff <= (apb_acc & ~pwrite) ? rd_word : RD_ZERO;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign nv_wr = nv_wr_ff;
   assign nv_wdata = nv_wdata_ff;
   assign disp_page = disp_page_ff;
   assign disp_value = disp_value_ff;
   assign disp_flash = disp_flash_ff;
   assign disp_err = err_ff;
   assign disp_na = disp_na_ff;
   assign disp_std = disp_std_ff;
   assign disp_model = model_ff;
   assign amp_activate = act_ff;
   assign amp_ext_feedback = ext_fb_ff;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_page_forward: assert property (fup && on_comp |=> page_ff == PG_MODE ##1 disp_page == PG_MODE)
      else $error("function up did not reach next parameter");
   a_page_back: assert property (fdn && !fup && on_comp |=> page_ff == PG_PWR)
      else $error("function down did not reach previous parameter");
   a_flash_shown: assert property (data_ev && !fn_move && (new_val != cur_val) && !commit |=> ##1 disp_flash)
      else $error("changed value not flashing");
   a_commit_store: assert property (commit_ok && on_comp && fault_en_ff && !capture |=> comp_ff == $past(pend_ff) && !edit_ff)
      else $error("commit did not store pending value");
   a_discard_pend: assert property (fn_move && !boot_ff |=> !edit_ff && mode_ff == $past(mode_ff) && pwr_ff == $past(pwr_ff))
      else $error("leaving parameter kept pending value");
   a_force_off: assert property (!fault_en_ff && !boot_ff |=> comp_ff == COMP_OFF)
      else $error("compensation not forced off");
   a_refuse_err: assert property (commit && illegal |=> err_ff ##1 disp_err)
      else $error("illegal commit not refused");
   a_info_once: assert property (info_ff |=> model_ff == $past(model_ff) && info_ff)
      else $error("amplifier info changed after capture");
   a_mode_toggle: assert property (on_mode && dup && !fn_move |=> pend_ff[0] == !$past(shown[0]) && edit_ff)
      else $error("mode did not toggle");
   a_no_transmit_at_power_up_boot: assert property (boot_ff && nv_rdata[NV_PWR] == PWR_NO_TRANSMIT_AT_POWER_UP |=> !amp_activate)
      else $error("amplifier active after no-transmit power-up");
   a_restore_boot: assert property (boot_ff && nv_rdata[NV_PWR] == PWR_RESTORE |=> amp_activate == $past(nv_rdata[NV_ACT]))
      else $error("activation not restored");
   a_na_shown: assert property (on_pwr && pwr_na_ff |=> disp_na && !edit_ff)
      else $error("power-up mode not shown as N/A");

   c_commit_ok: cover property (commit_ok && on_comp);
   c_refused: cover property (commit && illegal);
   c_capture: cover property (capture && supplies_ff);
   c_wrap: cover property (fup && on_pwr);
endmodule : scm_sspa_menu
`default_nettype wire

// ---- core/scm_sync.sv ----
// Two-flop synchroniser with rising-edge detection for a group of pins.
`timescale 1ns/1ns
`default_nettype none
module scm_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] raw,
   scm_sync_if.src port
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;
   logic [W-1:0] last_ff;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_ff <= '0;
         sync_ff <= '0;
         last_ff <= '0;
      end else begin
         meta_ff <= raw;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
      end
   end

   assign port.lvl = sync_ff;
   assign port.rise = sync_ff & ~last_ff;
endmodule : scm_sync
`default_nettype wire

// ---- shared/scm_pkg.sv ----
// Constants, register map and types shared by the amplifier menu block.
package scm_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_LOAD = 12'h004;
   localparam logic [11:0] ADDR_STAT = 12'h008;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
   // CTRL fields
   localparam int CTRL_FAULT_EN = 0;
   localparam int CTRL_ACT = 1;
   localparam int CTRL_SUPPLIES = 2;
   localparam int CTRL_PWR_NA = 3;
   localparam logic [3:0] CTRL_RST = 4'h1;
   // LOAD fields: bits 2..0 custom types, bit 3 individual table
   localparam int LOAD_W = 4;
   localparam int LOAD_TABLE = 3;
   // ----------------------------------------------------------------
   // Buttons and amplifier pins
   // ----------------------------------------------------------------
   localparam int BTN_W = 5;
   localparam int BTN_FUP = 0;
   localparam int BTN_FDN = 1;
   localparam int BTN_DUP = 2;
   localparam int BTN_DDN = 3;
   localparam int BTN_ENT = 4;
   localparam int MODEL_W = 16;
   localparam int AMP_W = 18;
   localparam int AMP_PRESENT = 16;
   localparam int AMP_HAS_CHAR = 17;
   // ----------------------------------------------------------------
   // Values
   // ----------------------------------------------------------------
   localparam int VAL_W = 3;
   localparam logic [2:0] COMP_OFF = 3'h0;
   localparam logic [2:0] COMP_STD_A = 3'h1;
   localparam int COMP_STD_LO = 1;
   localparam int COMP_CUST_LO = 4;
   localparam int COMP_TABLE = 7;
   localparam int COMP_N = 8;
   localparam logic MODE_EXT = 1'b0;
   localparam logic MODE_BASIC = 1'b1;
   localparam logic PWR_RESTORE = 1'b0;
   localparam logic PWR_NO_TRANSMIT_AT_POWER_UP = 1'b1;
   // Non-volatile word layout
   localparam int NV_W = 6;
   localparam int NV_MODE = 3;
   localparam int NV_PWR = 4;
   localparam int NV_ACT = 5;
   typedef enum logic [2:0] {
      PG_COMP = 3'b001,
      PG_MODE = 3'b010,
      PG_PWR = 3'b100
   } scm_page_t;
endpackage : scm_pkg

// ---- shared/scm_sync_if.sv ----
// Synchronised levels and rising-edge pulses between the input stage and the menu.
`timescale 1ns/1ns
`default_nettype none
interface scm_sync_if #(parameter int W = 1);
   logic [W-1:0] lvl;
   logic [W-1:0] rise;
   modport src (output lvl, output rise);
   modport dst (input lvl, input rise);
endinterface : scm_sync_if
`default_nettype wire

// ---- tb/scm_far_model.sv ----
// Far-side model: amplifier pins and the non-volatile settings store.
`timescale 1ns/1ns
`default_nettype none
module scm_far_model
   import scm_pkg::*;
#(
   parameter logic [MODEL_W-1:0] MODEL = 16'h0A5C
) (
   input wire logic clk,
   input wire logic nv_wr,
   input wire logic [NV_W-1:0] nv_wdata,
   input wire logic ld,
   input wire logic [NV_W-1:0] ld_word,
   input wire logic plug,
   output logic [NV_W-1:0] nv_rdata,
   output logic amp_present,
   output logic amp_has_char,
   output logic [MODEL_W-1:0] amp_model
);
   // ----------------------------------------------------------------
   // Store
   // ----------------------------------------------------------------
   // The word survives a reset of the block, as it would a power loss.
   logic [NV_W-1:0] word_ff;
   always_ff @(posedge clk) begin
      if (ld) begin
         word_ff <= ld_word;
      end else if (nv_wr) begin
         word_ff <= nv_wdata;
      end
   end
   assign nv_rdata = word_ff;
   // Plugging the amplifier in after a reset gives the menu its one capture.
   assign amp_present = plug;
   assign amp_has_char = plug;
   assign amp_model = MODEL;
endmodule : scm_far_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the amplifier menu block.
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import scm_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam logic [MODEL_W-1:0] MODEL = 16'h0A5C;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err;
   logic [BTN_W-1:0] btn_raw = 5'h00;
   logic amp_present, amp_has_char, nv_wr, ld = 1'b1;
   logic plug = 1'b1;
   logic [MODEL_W-1:0] amp_model, disp_model;
   logic [NV_W-1:0] nv_rdata, nv_wdata;
   logic [2:0] disp_page;
   logic [VAL_W-1:0] disp_value;
   logic disp_flash, disp_err, disp_na, disp_std, amp_activate, amp_ext_feedback;
   int n_fail = 0;
   int tests_run = 0;
   int cyc = 0;

   always #25 clk = ~clk;

   scm_sspa_menu u_dut (
      .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .btn_raw(btn_raw), .amp_present(amp_present),
      .amp_has_char(amp_has_char), .amp_model(amp_model), .nv_rdata(nv_rdata),
      .nv_wr(nv_wr), .nv_wdata(nv_wdata), .disp_page(disp_page),
      .disp_value(disp_value), .disp_flash(disp_flash), .disp_err(disp_err),
      .disp_na(disp_na), .disp_std(disp_std), .disp_model(disp_model),
      .amp_activate(amp_activate), .amp_ext_feedback(amp_ext_feedback)
   );

   scm_far_model #(.MODEL(MODEL)) u_far (
      .clk(clk), .nv_wr(nv_wr), .nv_wdata(nv_wdata), .ld(ld), .ld_word(6'h21), .plug(plug),
      .nv_rdata(nv_rdata), .amp_present(amp_present), .amp_has_char(amp_has_char),
      .amp_model(amp_model)
   );

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // The request stands until pready is seen high at a rising edge; the answer is taken there.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Held long enough to pass the synchroniser, then settled before checks.
   task automatic press(input int b);
      @(posedge clk);
      btn_raw[b] <= 1'b1;
      repeat (4) @(posedge clk);
      btn_raw[b] <= 1'b0;
      repeat (6) @(posedge clk);
      @(negedge clk);
   endtask : press

   task automatic do_reset();
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (8) @(posedge clk);
      @(negedge clk);
   endtask : do_reset

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test();
      end
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      int nb[4] = '{BTN_FUP, BTN_FUP, BTN_FDN, BTN_FDN};
      int np[4] = '{2, 4, 2, 1};
      int sv[6] = '{2, 3, 4, 7, 0, 1};
      @(posedge clk);
      ld <= 1'b0;
      do_reset();
      chk("activate", 32'(amp_activate), 1);
      chk("ext_fb", 32'(amp_ext_feedback), 1);
      chk("page", 32'(disp_page), 1);
      chk("model", 32'(disp_model), 32'(MODEL));
      apb(1'b0, ADDR_CTRL, 32'h0000_0000);
      chk("ctrl", rd & 32'h0000_000D, 32'h0000_0001);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk("slverr", 32'(err), 1);
      chk("unmapped", rd, 0);
      // Amplifier-supplied mode with the standard entry stored names the model.
      apb(1'b1, ADDR_CTRL, 32'h0000_0007);
      repeat (2) @(negedge clk);
      chk("std", 32'(disp_std), 1);
      apb(1'b1, ADDR_CTRL, 32'h0000_0003);
      apb(1'b0, ADDR_STAT, 32'h0000_0000);
      chk("stat", rd & 32'h0000_0E3F, 32'h0000_0221);
      $display("boot done");
      for (int i = 0; i < 4; i++) begin
         press(nb[i]);
         chk("page", 32'(disp_page), np[i]);
      end
      $display("navigation done");
      // Custom type one and the individual table are loaded.
      apb(1'b1, ADDR_LOAD, 32'h0000_0009);
      for (int i = 0; i < 6; i++) begin
         press(BTN_DUP);
         chk("scroll", 32'(disp_value), sv[i]);
      end
      press(BTN_DUP);
      chk("flash", 32'(disp_flash), 1);
      press(BTN_FUP);
      press(BTN_FDN);
      chk("kept", 32'(disp_value), 1);
      chk("flash", 32'(disp_flash), 0);
      press(BTN_DUP);
      press(BTN_ENT);
      chk("flash", 32'(disp_flash), 0);
      apb(1'b0, ADDR_STAT, 32'h0000_0000);
      chk("comp", rd & 32'h0000_0007, 2);
      // Disabling fault control drops a stored non-Off type at once.
      apb(1'b1, ADDR_CTRL, 32'h0000_0002);
      apb(1'b0, ADDR_STAT, 32'h0000_0000);
      chk("forced", rd & 32'h0000_0007, 0);
      apb(1'b1, ADDR_CTRL, 32'h0000_0003);
      $display("compensation list done");
      press(BTN_FUP);
      press(BTN_DUP);
      chk("mode", 32'(disp_value), 32'(MODE_BASIC));
      chk("flash", 32'(disp_flash), 1);
      press(BTN_ENT);
      chk("ext_fb", 32'(amp_ext_feedback), 0);
      press(BTN_FDN);
      press(BTN_DUP);
      press(BTN_ENT);
      chk("err", 32'(disp_err), 1);
      apb(1'b0, ADDR_STAT, 32'h0000_0000);
      chk("comp", rd & 32'h0000_0007, 0);
      // In Basic mode the operator steps back to Off and stores it.
      press(BTN_DDN);
      chk("err", 32'(disp_err), 0);
      press(BTN_ENT);
      chk("err", 32'(disp_err), 0);
      chk("flash", 32'(disp_flash), 0);
      press(BTN_FUP);
      $display("mode and refusal done");
      press(BTN_FUP);
      press(BTN_DUP);
      chk("pwr", 32'(disp_value), 32'(PWR_NO_TRANSMIT_AT_POWER_UP));
      press(BTN_ENT);
      chk("nv", 32'(u_far.word_ff), 32'h0000_0038);
      apb(1'b1, ADDR_CTRL, 32'h0000_000B);
      repeat (2) @(negedge clk);
      chk("na", 32'(disp_na), 1);
      apb(1'b1, ADDR_CTRL, 32'h0000_000A);
      apb(1'b0, ADDR_STAT, 32'h0000_0000);
      chk("forced", rd & 32'h0000_0007, 0);
      $display("power-up page done");
      // Unplugged across the reset, so the later plug-in is the one capture.
      plug <= 1'b0;
      do_reset();
      chk("activate", 32'(amp_activate), 0);
      chk("ext_fb", 32'(amp_ext_feedback), 0);
      apb(1'b1, ADDR_CTRL, 32'h0000_0005);
      plug <= 1'b1;
      repeat (6) @(negedge clk);
      chk("auto", 32'(disp_value), 32'(COMP_STD_A));
      chk("std", 32'(disp_std), 1);
      $display("power cycle done");
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
